// File: design/plda_lock_assist.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "plda_defs.svh"

module plda_lock_assist
  import plda_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_chip_enable,
  input wire plda_phase_err_t i_phase_err,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_test_lock_output,
  output logic [3:0] o_cp_current,
  output logic o_boost_parallel_resistor,
  output logic [2:0] o_cmp_div_shift,
  output logic [1:0] o_loop_powered,
  output logic o_irq
);

  plda_state_t state;
  plda_state_t next_state;
  plda_bus_req_t req;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Returns {locked, good count} after one lock-detector step
  function automatic logic [3:0] lock_step(input logic locked, input logic [2:0] cnt,
                                           input logic [7:0] err, input logic [7:0] thr_lock,
                                           input logic [7:0] thr_unlock, input logic sample);
    logic l;
    logic [2:0] c;
    l = locked;
    c = cnt;
    if (sample) begin
      if (!locked) begin
        if (err < thr_lock) begin
          c = cnt + 3'd1;
          if (c >= `PLDA_LOCK_CYCLES) begin
            l = 1'b1;
            c = 3'd0;
          end
        end else begin
          c = 3'd0;
        end
      end else if (err > thr_unlock) begin
        l = 1'b0;
        c = 3'd0;
      end
    end
    lock_step = {l, c};
  endfunction

  function automatic logic [2:0] csr_shift(input plda_csr_factor_t f);
    case (f)
      PLDA_CSR_HALF: csr_shift = `PLDA_SHIFT_HALF;
      PLDA_CSR_QUARTER: csr_shift = `PLDA_SHIFT_QUARTER;
      PLDA_CSR_SIXTEENTH: csr_shift = `PLDA_SHIFT_SIXTEENTH;
      default: csr_shift = `PLDA_SHIFT_NONE;
    endcase
  endfunction

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_comb begin
    logic div_wr;
    logic sample;
    logic [3:0] step_main;
    logic [3:0] step_aux;
    logic [1:0] pwr;
    logic [4:0] ev;
    logic csr_on;
    logic boost_on;
    logic [1:0] lk;
    div_wr = 1'b0;
    sample = 1'b0;
    step_main = 4'h0;
    step_aux = 4'h0;
    pwr = 2'b00;
    ev = 5'h00;
    csr_on = 1'b0;
    boost_on = 1'b0;
    lk = 2'b00;
    next_state = state;

    // Register writes
    if (req.wr) begin
      if (hit(req.addr, `PLDA_OFF_CTRL)) begin
        next_state.prescale = req.wdata[`PLDA_CTRL_PRESCALE];
        next_state.csr_en = req.wdata[`PLDA_CTRL_CSR_EN];
        next_state.csr_factor = plda_csr_factor_t'(req.wdata[`PLDA_CTRL_CSR_HI:`PLDA_CTRL_CSR_LO]);
        next_state.boost_en = req.wdata[`PLDA_CTRL_BOOST_EN];
        next_state.main_pd = req.wdata[`PLDA_CTRL_MAIN_PD];
        next_state.aux_pd = req.wdata[`PLDA_CTRL_AUX_PD];
      end
      if (hit(req.addr, `PLDA_OFF_OUTSEL)) begin
        next_state.out_sel = req.wdata[3:0];
      end
      if (hit(req.addr, `PLDA_OFF_CP)) begin
        next_state.cp_steady = req.wdata[`PLDA_CP_STEADY_HI:`PLDA_CP_STEADY_LO];
        next_state.cp_acq = req.wdata[`PLDA_CP_ACQ_HI:`PLDA_CP_ACQ_LO];
      end
      if (hit(req.addr, `PLDA_OFF_TIMEOUT)) begin
        next_state.timeout = req.wdata[15:0];
      end
      if (hit(req.addr, `PLDA_OFF_MAIN_DIV)) begin
        next_state.main_div = req.wdata[21:0];
        div_wr = 1'b1;
      end
      if (hit(req.addr, `PLDA_OFF_IRQ_ENABLE)) begin
        next_state.irq_en = req.wdata[4:0];
      end
    end

    // Chip enable overrides the per-loop power-down bits
    pwr[0] = i_chip_enable && !state.main_pd;
    pwr[1] = i_chip_enable && !state.aux_pd;
    next_state.powered = pwr;

    // Lock detector, optionally decimated to one sample in four
    next_state.div_cnt = state.div_cnt + 2'd1;
    sample = !state.prescale || (state.div_cnt == `PLDA_PRESCALE_LAST);
    step_main = lock_step(state.locked[0], state.good_cnt[0], i_phase_err.main,
                          `PLDA_MAIN_LOCK_NS, `PLDA_MAIN_UNLOCK_NS, sample);
    step_aux = lock_step(state.locked[1], state.good_cnt[1], i_phase_err.aux,
                         `PLDA_AUX_LOCK_NS, `PLDA_AUX_UNLOCK_NS, sample);
    next_state.locked = {step_aux[3], step_main[3]};
    next_state.good_cnt[0] = step_main[2:0];
    next_state.good_cnt[1] = step_aux[2:0];
    if (!pwr[0]) begin
      next_state.locked[0] = 1'b0;
      next_state.good_cnt[0] = 3'd0;
    end
    if (!pwr[1]) begin
      next_state.locked[1] = 1'b0;
      next_state.good_cnt[1] = 3'd0;
    end

    // Acquisition assist timeout
    if (state.assist) begin
      if (state.assist_cnt == 16'h0000) begin
        next_state.assist = 1'b0;
        ev[`PLDA_IRQ_ASSIST_DONE] = 1'b1;
      end else begin
        next_state.assist_cnt = state.assist_cnt - 16'h0001;
      end
    end
    if (!pwr[0]) begin
      next_state.assist = 1'b0;
    end

    // Divider write restarts detector and assist counters, not the registers
    if (div_wr) begin
      next_state.div_cnt = 2'd0;
      next_state.good_cnt = '0;
      next_state.locked = 2'b00;
      next_state.assist = (state.csr_en || state.boost_en) && pwr[0];
      next_state.assist_cnt = state.timeout;
      ev[`PLDA_IRQ_ASSIST_DONE] = 1'b0;
    end

    csr_on = next_state.assist && state.csr_en;
    boost_on = next_state.assist && state.boost_en;
    next_state.cmp_shift = csr_on ? csr_shift(state.csr_factor) : `PLDA_SHIFT_NONE;
    // Reduction also runs the acquisition current so the loop gain ratio holds
    next_state.cp_out = (boost_on || csr_on) ? state.cp_acq : state.cp_steady;
    next_state.r2p = boost_on;

    // Test output; lock views follow next lock state, forced low when powered down
    lk = next_state.locked & pwr;
    case (plda_out_sel_t'(state.out_sel))
      PLDA_SEL_MAIN_LOCK: next_state.test_out = lk[0];
      PLDA_SEL_AUX_LOCK: next_state.test_out = lk[1];
      PLDA_SEL_BOTH_LOCK: next_state.test_out = &lk;
      PLDA_SEL_HIGH: next_state.test_out = 1'b1;
      default: next_state.test_out = 1'b0;
    endcase

    // Lock gain and loss events
    ev[`PLDA_IRQ_MAIN_LOCK] = !state.locked[0] && next_state.locked[0];
    ev[`PLDA_IRQ_MAIN_LOSS] = state.locked[0] && !next_state.locked[0];
    ev[`PLDA_IRQ_AUX_LOCK] = !state.locked[1] && next_state.locked[1];
    ev[`PLDA_IRQ_AUX_LOSS] = state.locked[1] && !next_state.locked[1];

    // A new event wins over a clear in the same cycle
    if (req.wr && hit(req.addr, `PLDA_OFF_IRQ_CLEAR)) begin
      next_state.irq_status = state.irq_status & ~req.wdata[4:0];
    end
    next_state.irq_status = next_state.irq_status | ev;
    next_state.irq = |(next_state.irq_status & next_state.irq_en);

    // Read data stands only in the cycle after the strobe
    next_state.rdata = 32'h0000_0000;
    if (req.rd) begin
      if (hit(req.addr, `PLDA_OFF_CTRL)) begin
        next_state.rdata[6:0] = {state.aux_pd, state.main_pd, state.boost_en, state.csr_factor,
                                 state.csr_en, state.prescale};
      end else if (hit(req.addr, `PLDA_OFF_OUTSEL)) begin
        next_state.rdata[3:0] = state.out_sel;
      end else if (hit(req.addr, `PLDA_OFF_CP)) begin
        next_state.rdata[7:0] = {state.cp_acq, state.cp_steady};
      end else if (hit(req.addr, `PLDA_OFF_TIMEOUT)) begin
        next_state.rdata[15:0] = state.timeout;
      end else if (hit(req.addr, `PLDA_OFF_MAIN_DIV)) begin
        next_state.rdata[21:0] = state.main_div;
      end else if (hit(req.addr, `PLDA_OFF_STATUS)) begin
        next_state.rdata[6:0] = {state.powered, state.r2p, |state.cmp_shift, state.assist, state.locked};
      end else if (hit(req.addr, `PLDA_OFF_IRQ_STATUS)) begin
        next_state.rdata[4:0] = state.irq_status;
      end else if (hit(req.addr, `PLDA_OFF_IRQ_ENABLE)) begin
        next_state.rdata[4:0] = state.irq_en;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= '0;
      state.out_sel <= `PLDA_RST_OUTSEL;
      state.cp_steady <= `PLDA_RST_CP_STEADY;
      state.cp_acq <= `PLDA_RST_CP_ACQ;
      state.timeout <= `PLDA_RST_TIMEOUT;
      state.main_div <= `PLDA_RST_MAIN_DIV;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_test_lock_output = state.test_out;
  assign o_cp_current = state.cp_out;
  assign o_boost_parallel_resistor = state.r2p;
  assign o_cmp_div_shift = state.cmp_shift;
  assign o_loop_powered = state.powered;
  assign o_irq = state.irq;

endmodule

// File: shared/plda_defs.svh
`ifndef PLDA_DEFS_SVH
`define PLDA_DEFS_SVH

// Register byte offsets
`define PLDA_OFF_CTRL 8'h00
`define PLDA_OFF_OUTSEL 8'h04
`define PLDA_OFF_CP 8'h08
`define PLDA_OFF_TIMEOUT 8'h0c
`define PLDA_OFF_MAIN_DIV 8'h10
`define PLDA_OFF_STATUS 8'h14
`define PLDA_OFF_IRQ_STATUS 8'h18
`define PLDA_OFF_IRQ_CLEAR 8'h1c
`define PLDA_OFF_IRQ_ENABLE 8'h20

// Control register fields
`define PLDA_CTRL_PRESCALE 0
`define PLDA_CTRL_CSR_EN 1
`define PLDA_CTRL_CSR_LO 2
`define PLDA_CTRL_CSR_HI 3
`define PLDA_CTRL_BOOST_EN 4
`define PLDA_CTRL_MAIN_PD 5
`define PLDA_CTRL_AUX_PD 6

// Charge-pump register fields
`define PLDA_CP_STEADY_LO 0
`define PLDA_CP_STEADY_HI 3
`define PLDA_CP_ACQ_LO 4
`define PLDA_CP_ACQ_HI 7

// Interrupt bits
`define PLDA_IRQ_MAIN_LOCK 0
`define PLDA_IRQ_MAIN_LOSS 1
`define PLDA_IRQ_AUX_LOCK 2
`define PLDA_IRQ_AUX_LOSS 3
`define PLDA_IRQ_ASSIST_DONE 4

// Reset values
`define PLDA_RST_CTRL 7'h00
`define PLDA_RST_OUTSEL 4'h0
`define PLDA_RST_CP_STEADY 4'h0
`define PLDA_RST_CP_ACQ 4'hf
`define PLDA_RST_TIMEOUT 16'h0100
`define PLDA_RST_MAIN_DIV 22'h000000

// Lock thresholds in ns, phase error arrives in 1 ns units
`define PLDA_MAIN_LOCK_NS 8'd10
`define PLDA_MAIN_UNLOCK_NS 8'd20
`define PLDA_AUX_LOCK_NS 8'd15
`define PLDA_AUX_UNLOCK_NS 8'd30
`define PLDA_LOCK_CYCLES 3'd5
`define PLDA_PRESCALE_LAST 2'd3

// Comparison-rate divide shifts during cycle-slip reduction
`define PLDA_SHIFT_NONE 3'd0
`define PLDA_SHIFT_HALF 3'd1
`define PLDA_SHIFT_QUARTER 3'd2
`define PLDA_SHIFT_SIXTEENTH 3'd4

`endif

// File: shared/plda_pkg.sv
package plda_pkg;

  typedef enum logic [1:0] {
    PLDA_CSR_HALF = 2'b00,
    PLDA_CSR_QUARTER = 2'b01,
    PLDA_CSR_SIXTEENTH = 2'b10,
    PLDA_CSR_RSVD = 2'b11
  } plda_csr_factor_t;

  typedef enum logic [3:0] {
    PLDA_SEL_LOW = 4'b0000,
    PLDA_SEL_MAIN_LOCK = 4'b0001,
    PLDA_SEL_AUX_LOCK = 4'b0010,
    PLDA_SEL_BOTH_LOCK = 4'b0011,
    PLDA_SEL_HIGH = 4'b0100
  } plda_out_sel_t;

  typedef struct packed {
    logic [7:0] main;
    logic [7:0] aux;
  } plda_phase_err_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } plda_bus_req_t;

  typedef struct packed {
    logic prescale;
    logic csr_en;
    plda_csr_factor_t csr_factor;
    logic boost_en;
    logic main_pd;
    logic aux_pd;
    logic [3:0] out_sel;
    logic [3:0] cp_steady;
    logic [3:0] cp_acq;
    logic [15:0] timeout;
    logic [21:0] main_div;
    logic [1:0] div_cnt;
    logic [1:0] locked;
    logic [1:0][2:0] good_cnt;
    logic assist;
    logic [15:0] assist_cnt;
    logic [4:0] irq_status;
    logic [4:0] irq_en;
    logic [31:0] rdata;
    logic test_out;
    logic [3:0] cp_out;
    logic r2p;
    logic [2:0] cmp_shift;
    logic irq;
    logic [1:0] powered;
  } plda_state_t;

endpackage

// File: testbench/plda_lock_assist_checker.sv
`timescale 1ns/100ps
`include "plda_defs.svh"
module plda_lock_assist_checker
  import plda_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_chip_enable,
  input wire plda_phase_err_t i_phase_err,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_test_lock_output,
  input wire logic [3:0] o_cp_current,
  input wire logic o_boost_parallel_resistor,
  input wire logic [2:0] o_cmp_div_shift,
  input wire logic [1:0] o_loop_powered,
  input wire logic o_irq
);
  logic [6:0] ctrl;
  logic [3:0] sel;
  logic [3:0] acq;
  logic [2:0] good;
  logic [2:0] exp_shift;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Shadow of the control, output-select and acquisition-current fields and a count of good main-loop samples, since the checker only sees the pins
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl <= 7'h00;
      sel <= 4'h0;
      acq <= 4'hf;
      good <= 3'h0;
    end else begin
      if (i_wr && i_addr == `PLDA_OFF_CTRL) ctrl <= i_wdata[6:0];
      if (i_wr && i_addr == `PLDA_OFF_OUTSEL) sel <= i_wdata[3:0];
      if (i_wr && i_addr == `PLDA_OFF_CP) acq <= i_wdata[7:4];
      good <= (i_phase_err.main >= 8'h0a) ? 3'h0 : (good == 3'h7) ? good : good + 3'h1;
    end
  end
  always_comb begin
    exp_shift = (ctrl[3:2] == 2'h3) ? 3'h0 : 3'(1 << ctrl[3:2]);
  end
  sequence s_div_wr;
    i_wr && i_addr == `PLDA_OFF_MAIN_DIV && o_loop_powered[0];
  endsequence
  AST_LOCK_FIVE: assert property ($rose(o_test_lock_output) && sel == PLDA_SEL_MAIN_LOCK && sel == $past(sel, 2) && !ctrl[0] |-> good >= 3'h5) else $error("lock rose too early");
  AST_UNLOCK: assert property (o_test_lock_output && i_phase_err.main > 8'h14 && !ctrl[0] && sel == PLDA_SEL_MAIN_LOCK && sel == $past(sel, 2) |=> !o_test_lock_output) else $error("lock not dropped");
  AST_PD_LOW: assert property (sel == PLDA_SEL_MAIN_LOCK && sel == $past(sel, 2) && !o_loop_powered[0] && !$past(o_loop_powered[0]) |-> !o_test_lock_output) else $error("lock view high in power down");
  AST_BOTH_LOW: assert property (sel == PLDA_SEL_BOTH_LOCK && sel == $past(sel, 2) && !o_loop_powered[1] && !$past(o_loop_powered[1]) |-> !o_test_lock_output) else $error("combined view high");
  AST_CSR_SHIFT: assert property (s_div_wr ##0 ctrl[1] |-> ##2 o_cmp_div_shift == exp_shift) else $error("wrong rate divide");
  AST_CP_ACQ: assert property (o_boost_parallel_resistor && $stable(acq) |-> o_cp_current == acq) else $error("boost without acquisition current");
  AST_BOOST_ON: assert property (s_div_wr ##0 ctrl[4] |-> ##2 o_boost_parallel_resistor && o_cp_current == acq) else $error("boost not engaged");
  AST_CE_OFF: assert property (!i_chip_enable |=> o_loop_powered == 2'b00) else $error("loops powered with chip disabled");
endmodule
bind plda_lock_assist plda_lock_assist_checker u_chk (.i_ref_clk, .i_reset, .i_chip_enable, .i_phase_err, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_test_lock_output, .o_cp_current, .o_boost_parallel_resistor,
  .o_cmp_div_shift, .o_loop_powered, .o_irq);

// File: testbench/plda_loop_model.sv
`timescale 1ns/100ps
module plda_loop_model
  import plda_pkg::*;
(
  input wire logic i_ref_clk,
  input wire plda_phase_err_t i_target,
  output plda_phase_err_t o_phase_err
);
  // The measured error lags the commanded one by a cycle, like a real detector
  always_ff @(posedge i_ref_clk) begin
    o_phase_err <= i_target;
  end
endmodule

// File: testbench/pll_lock_detect_acq_assist_tb_top.sv
`timescale 1ns/100ps
`include "plda_defs.svh"
module pll_lock_detect_acq_assist_tb_top
  import plda_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_chip_enable = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  plda_phase_err_t target = 16'h3232;
  plda_phase_err_t i_phase_err;
  logic [31:0] o_rdata;
  logic o_test_lock_output;
  logic [3:0] o_cp_current;
  logic o_boost_parallel_resistor;
  logic [2:0] o_cmp_div_shift;
  logic [1:0] o_loop_powered;
  logic o_irq;
  logic [7:0] lo;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  plda_loop_model u_loop (.i_ref_clk, .i_target(target), .o_phase_err(i_phase_err));
  plda_lock_assist DUT (.i_ref_clk, .i_reset, .i_chip_enable, .i_phase_err, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_test_lock_output, .o_cp_current, .o_boost_parallel_resistor, .o_cmp_div_shift, .o_loop_powered, .o_irq);
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run hung", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic seterr(input int l, input logic [7:0] v);
    @(posedge i_ref_clk);
    if (l == 0) target.main <= v;
    else target.aux <= v;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(`PLDA_OFF_CTRL, 32'h0);
    rd(`PLDA_OFF_CP, 32'hf0);
    rd(`PLDA_OFF_TIMEOUT, 32'h100);
    wr(`PLDA_OFF_STATUS, 32'hff);
    rd(`PLDA_OFF_STATUS, 32'h60);
    rd(8'h40, 32'h0);
    $display("test registers done");
    for (int l = 0; l < 2; l++) begin
      lo = (l == 0) ? 8'h0a : 8'h0f;
      wr(`PLDA_OFF_OUTSEL, l + 1);
      seterr(l, lo);
      cyc(8);
      chkb(o_test_lock_output, 1'b0);
      seterr(l, lo - 8'h1);
      cyc(5);
      chkb(o_test_lock_output, 1'b0);
      cyc(1);
      chkb(o_test_lock_output, 1'b1);
      seterr(l, lo << 1);
      cyc(8);
      chkb(o_test_lock_output, 1'b1);
      seterr(l, (lo << 1) + 8'h1);
      cyc(1);
      chkb(o_test_lock_output, 1'b1);
      cyc(1);
      chkb(o_test_lock_output, 1'b0);
    end
    $display("test hysteresis done");
    wr(`PLDA_OFF_OUTSEL, 32'h3);
    seterr(0, 8'h05);
    seterr(1, 8'h05);
    cyc(8);
    chkb(o_test_lock_output, 1'b1);
    seterr(1, 8'h1f);
    cyc(3);
    chkb(o_test_lock_output, 1'b0);
    wr(`PLDA_OFF_OUTSEL, 32'h1);
    cyc(3);
    chkb(o_test_lock_output, 1'b1);
    wr(`PLDA_OFF_CTRL, 32'h20);
    cyc(3);
    chkb(o_test_lock_output, 1'b0);
    chk({30'h0, o_loop_powered}, 32'h2);
    wr(`PLDA_OFF_CTRL, 32'h0);
    i_chip_enable <= 1'b0;
    cyc(2);
    chk({30'h0, o_loop_powered}, 32'h0);
    @(posedge i_ref_clk);
    i_chip_enable <= 1'b1;
    cyc(7);
    chkb(o_test_lock_output, 1'b1);
    wr(`PLDA_OFF_MAIN_DIV, 32'h0);
    cyc(2);
    chkb(o_test_lock_output, 1'b0);
    cyc(8);
    chkb(o_test_lock_output, 1'b1);
    seterr(0, 8'h32);
    wr(`PLDA_OFF_CTRL, 32'h1);
    seterr(0, 8'h05);
    cyc(12);
    chkb(o_test_lock_output, 1'b0);
    cyc(14);
    chkb(o_test_lock_output, 1'b1);
    seterr(0, 8'h32);
    wr(`PLDA_OFF_CTRL, 32'h0);
    $display("test power and prescale done");
    wr(`PLDA_OFF_IRQ_CLEAR, 32'h1f);
    rd(`PLDA_OFF_IRQ_STATUS, 32'h0);
    wr(`PLDA_OFF_IRQ_ENABLE, 32'h10);
    wr(`PLDA_OFF_CP, 32'h82);
    wr(`PLDA_OFF_TIMEOUT, 32'h4);
    wr(`PLDA_OFF_CTRL, 32'h10);
    wr(`PLDA_OFF_MAIN_DIV, 32'h1234);
    cyc(1);
    chk({o_boost_parallel_resistor, o_cp_current}, 32'h18);
    cyc(3);
    chkb(o_boost_parallel_resistor, 1'b1);
    cyc(1);
    chkb(o_boost_parallel_resistor, 1'b0);
    cyc(1);
    chk({o_boost_parallel_resistor, o_cp_current}, 32'h2);
    chkb(o_irq, 1'b1);
    rd(`PLDA_OFF_MAIN_DIV, 32'h1234);
    rd(`PLDA_OFF_IRQ_STATUS, 32'h10);
    wr(`PLDA_OFF_IRQ_CLEAR, 32'h10);
    cyc(2);
    chkb(o_irq, 1'b0);
    $display("test boost done");
    wr(`PLDA_OFF_IRQ_ENABLE, 32'h0);
    wr(`PLDA_OFF_CP, 32'h41);
    for (int f = 0; f < 3; f++) begin
      wr(`PLDA_OFF_CTRL, 32'h2 | (f << 2));
      wr(`PLDA_OFF_MAIN_DIV, 32'h5);
      cyc(1);
      chk({29'h0, o_cmp_div_shift}, 32'(1 << f));
      cyc(6);
      chk({29'h0, o_cmp_div_shift}, 32'h0);
    end
    rd(`PLDA_OFF_IRQ_STATUS, 32'h10);
    chkb(o_irq, 1'b0);
    $display("test reduction done");
    complete_run();
  end
endmodule
